// ### verilog/ltc_pkg.sv
// Constants for the link test constant register bank.
// Used by the design only; the bench repeats the values itself; no process logic here.
package ltc_pkg;
  localparam int unsigned LTC_DW = 16;
  localparam int unsigned LTC_AW = 16;

  // Register addresses in the node's register space
  localparam logic [15:0] LTC_ADDR_CHANNEL = 16'h1040;
  localparam logic [15:0] LTC_ADDR_ALL_CLEAR = 16'h2000;
  localparam logic [15:0] LTC_ADDR_ALL_SET = 16'h2001;
  localparam logic [15:0] LTC_ADDR_BYTE_ORDER = 16'h2002;
  localparam logic [15:0] LTC_ADDR_MASK_UPPER = 16'h2003;
  localparam logic [15:0] LTC_ADDR_MASK_LOWER = 16'h2004;
  localparam logic [15:0] LTC_ADDR_TOP_POS = 16'h2005;
  localparam logic [15:0] LTC_ADDR_TOP_NEG = 16'h2006;
  localparam logic [15:0] LTC_ADDR_HALF_POS = 16'h2007;
  localparam logic [15:0] LTC_ADDR_HALF_NEG = 16'h2008;

  // Fixed values returned by the constant registers
  localparam logic [15:0] LTC_VAL_ALL_CLEAR = 16'h0000;
  localparam logic [15:0] LTC_VAL_ALL_SET = 16'hffff;
  localparam logic [15:0] LTC_VAL_BYTE_ORDER = 16'h1234;
  localparam logic [15:0] LTC_VAL_MASK_UPPER = 16'haaaa;
  localparam logic [15:0] LTC_VAL_MASK_LOWER = 16'h5555;
  localparam logic [15:0] LTC_VAL_TOP_POS = 16'h7fff;
  localparam logic [15:0] LTC_VAL_TOP_NEG = 16'h8000;
  localparam logic [15:0] LTC_VAL_HALF_POS = 16'h3fff;
  localparam logic [15:0] LTC_VAL_HALF_NEG = 16'hc000;

  // Reset values
  localparam logic [15:0] LTC_RST_CHANNEL = 16'h0000;
  localparam logic [15:0] LTC_RST_DATA = 16'h0000;

  typedef struct packed {
    logic hit;
    logic [15:0] value;
  } ltc_lookup_t;
endpackage : ltc_pkg

// ### verilog/ltc_regs.sv
// Link test constant register bank with the debug process-data channel.
// Assumes one request per cycle at most from the fieldbus register-access
// engine on the same clock; the control program side is on the same clock.
//
// Overview of operation
// - Base register 0x2000 always reads as all zero bits.
// - Register 0x2001 reads all ones: minus one signed, maximum unsigned.
// - Register 0x2002 reads 0x1234 so byte positions can be checked.
// - Registers 0x2003 and 0x2004 read complementary alternating masks.
// - Read-only signed limits: top positive, top negative, half positive, half negative.
// - Channel register 0x1040 accepts reads and writes between tool and program.
// - Channel register only has meaning in the programmable controller core variant.
`timescale 1ns/1ps
`default_nettype none
module ltc_regs
  import ltc_pkg::*;
#(
  parameter bit PROGRAMMABLE_CONTROLLER_CORE = 1'b1
) (
  input wire logic clk,
  input wire logic rstn,
  // Register access from the fieldbus side
  input wire logic req,
  input wire logic req_write,
  input wire logic [LTC_AW-1:0] req_addr,
  input wire logic [LTC_DW-1:0] req_wdata,
  output logic rsp_valid,
  output logic rsp_err,
  output logic [LTC_DW-1:0] rsp_rdata,
  // Control program side of the channel
  input wire logic prog_write,
  input wire logic [LTC_DW-1:0] prog_wdata,
  output logic [LTC_DW-1:0] chan_data,
  output logic chan_master_wrote
);

  typedef struct packed {
    logic rsp_valid;
    logic rsp_err;
    logic [LTC_DW-1:0] rsp_rdata;
    logic [LTC_DW-1:0] chan;
    logic chan_master_wrote;
  } ltc_state_t;

  // Register selected by an address; the channel code only exists in the controller core
  typedef enum logic [3:0] {
    LTC_REG_NONE = 4'b0000,
    LTC_REG_CHANNEL = 4'b0001,
    LTC_REG_ALL_CLEAR = 4'b0010,
    LTC_REG_ALL_SET = 4'b0011,
    LTC_REG_BYTE_ORDER = 4'b0100,
    LTC_REG_MASK_UPPER = 4'b0101,
    LTC_REG_MASK_LOWER = 4'b0110,
    LTC_REG_TOP_POS = 4'b0111,
    LTC_REG_TOP_NEG = 4'b1000,
    LTC_REG_HALF_POS = 4'b1001,
    LTC_REG_HALF_NEG = 4'b1010
  } ltc_reg_t;

  // Kind of access taken on one edge; every answer field follows from it
  typedef enum logic [2:0] {
    LTC_ACC_NONE = 3'b000,
    LTC_ACC_CONST_READ = 3'b001,
    LTC_ACC_CONST_WRITE = 3'b010,
    LTC_ACC_CHAN_READ = 3'b011,
    LTC_ACC_CHAN_WRITE = 3'b100,
    LTC_ACC_REFUSED = 3'b101
  } ltc_access_t;

  ltc_state_t state;
  ltc_state_t next_state;
  ltc_access_t acc;

  // Address decode shared by the answer path and the channel path
  function automatic ltc_reg_t reg_of(input logic [LTC_AW-1:0] a, input logic has_channel);
    ltc_reg_t r;
    r = LTC_REG_NONE;
    case (a)
      LTC_ADDR_CHANNEL: begin
        // Coupler variant leaves this address unmapped
        r = has_channel ? LTC_REG_CHANNEL : LTC_REG_NONE;
      end
      LTC_ADDR_ALL_CLEAR: begin
        r = LTC_REG_ALL_CLEAR;
      end
      LTC_ADDR_ALL_SET: begin
        r = LTC_REG_ALL_SET;
      end
      LTC_ADDR_BYTE_ORDER: begin
        r = LTC_REG_BYTE_ORDER;
      end
      LTC_ADDR_MASK_UPPER: begin
        r = LTC_REG_MASK_UPPER;
      end
      LTC_ADDR_MASK_LOWER: begin
        r = LTC_REG_MASK_LOWER;
      end
      LTC_ADDR_TOP_POS: begin
        r = LTC_REG_TOP_POS;
      end
      LTC_ADDR_TOP_NEG: begin
        r = LTC_REG_TOP_NEG;
      end
      LTC_ADDR_HALF_POS: begin
        r = LTC_REG_HALF_POS;
      end
      LTC_ADDR_HALF_NEG: begin
        r = LTC_REG_HALF_NEG;
      end
      default: begin
        r = LTC_REG_NONE;
      end
    endcase
    return r;
  endfunction

  // Pure decode: no state feeds it, so values never drift
  function automatic ltc_lookup_t const_lookup(input logic [LTC_AW-1:0] a);
    ltc_lookup_t c;
    c.hit = 1'b1;
    c.value = LTC_RST_DATA;
    case (reg_of(a, 1'b0))
      LTC_REG_ALL_CLEAR: begin
        c.value = LTC_VAL_ALL_CLEAR;
      end
      LTC_REG_ALL_SET: begin
        c.value = LTC_VAL_ALL_SET;
      end
      LTC_REG_BYTE_ORDER: begin
        c.value = LTC_VAL_BYTE_ORDER;
      end
      LTC_REG_MASK_UPPER: begin
        c.value = LTC_VAL_MASK_UPPER;
      end
      LTC_REG_MASK_LOWER: begin
        c.value = LTC_VAL_MASK_LOWER;
      end
      LTC_REG_TOP_POS: begin
        c.value = LTC_VAL_TOP_POS;
      end
      LTC_REG_TOP_NEG: begin
        c.value = LTC_VAL_TOP_NEG;
      end
      LTC_REG_HALF_POS: begin
        c.value = LTC_VAL_HALF_POS;
      end
      LTC_REG_HALF_NEG: begin
        c.value = LTC_VAL_HALF_NEG;
      end
      default: begin
        // Channel and unmapped addresses hold no constant
        c.hit = 1'b0;
        c.value = LTC_RST_DATA;
      end
    endcase
    return c;
  endfunction

  // Refused covers unmapped addresses and the channel in the coupler variant
  function automatic ltc_access_t decode_access(
    input logic valid,
    input logic write,
    input logic [LTC_AW-1:0] a,
    input logic has_channel
  );
    ltc_access_t k;
    ltc_reg_t r;
    ltc_lookup_t c;
    r = reg_of(a, has_channel);
    c = const_lookup(a);
    k = LTC_ACC_NONE;
    if (!valid) begin
      k = LTC_ACC_NONE;
    end else if (r == LTC_REG_CHANNEL) begin
      if (write) begin
        k = LTC_ACC_CHAN_WRITE;
      end else begin
        k = LTC_ACC_CHAN_READ;
      end
    end else if (c.hit) begin
      if (write) begin
        k = LTC_ACC_CONST_WRITE;
      end else begin
        k = LTC_ACC_CONST_READ;
      end
    end else begin
      k = LTC_ACC_REFUSED;
    end
    return k;
  endfunction

  // Only the answered kinds raise the valid pulse
  function automatic logic is_answered(input ltc_access_t k);
    logic v;
    case (k)
      LTC_ACC_NONE: begin
        v = 1'b0;
      end
      default: begin
        v = 1'b1;
      end
    endcase
    return v;
  endfunction

  function automatic logic is_refused(input ltc_access_t k);
    logic e;
    case (k)
      LTC_ACC_REFUSED: begin
        e = 1'b1;
      end
      default: begin
        // Writes to constants are accepted without an error
        e = 1'b0;
      end
    endcase
    return e;
  endfunction

  function automatic logic is_channel_write(input ltc_access_t k);
    logic w;
    case (k)
      LTC_ACC_CHAN_WRITE: begin
        w = 1'b1;
      end
      default: begin
        w = 1'b0;
      end
    endcase
    return w;
  endfunction

  // Writes and refusals answer with zero so no stale word leaks out
  function automatic logic [LTC_DW-1:0] answer_word(
    input ltc_access_t k,
    input logic [LTC_AW-1:0] a,
    input logic [LTC_DW-1:0] chan
  );
    ltc_lookup_t c;
    logic [LTC_DW-1:0] w;
    c = const_lookup(a);
    w = LTC_RST_DATA;
    case (k)
      LTC_ACC_CONST_READ: begin
        w = c.value;
      end
      LTC_ACC_CHAN_READ: begin
        // Content before any write taken on the same edge
        w = chan;
      end
      default: begin
        w = LTC_RST_DATA;
      end
    endcase
    return w;
  endfunction

  // Master data wins when both sides write the channel on one edge
  function automatic logic [LTC_DW-1:0] channel_next(
    input logic [LTC_DW-1:0] chan,
    input ltc_access_t k,
    input logic [LTC_DW-1:0] master_data,
    input logic prog_strobe,
    input logic [LTC_DW-1:0] prog_data,
    input logic has_channel
  );
    logic [LTC_DW-1:0] n;
    n = chan;
    if (has_channel && prog_strobe) begin
      n = prog_data;
    end
    if (is_channel_write(k)) begin
      n = master_data;
    end
    return n;
  endfunction

  always_comb begin
    acc = decode_access(req, req_write, req_addr, PROGRAMMABLE_CONTROLLER_CORE);
    next_state = state;
    next_state.rsp_valid = is_answered(acc);
    next_state.rsp_err = is_refused(acc);
    next_state.rsp_rdata = answer_word(acc, req_addr, state.chan);
    next_state.chan = channel_next(state.chan, acc, req_wdata, prog_write, prog_wdata,
      PROGRAMMABLE_CONTROLLER_CORE);
    next_state.chan_master_wrote = is_channel_write(acc);
  end

  // Constants need no storage, so only the answer and the channel reset
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      state.rsp_valid <= 1'b0;
      state.rsp_err <= 1'b0;
      state.rsp_rdata <= LTC_RST_DATA;
      state.chan <= LTC_RST_CHANNEL;
      state.chan_master_wrote <= 1'b0;
    end else begin
      state <= next_state;
    end
  end

  assign rsp_valid = state.rsp_valid;
  assign rsp_err = state.rsp_err;
  assign rsp_rdata = state.rsp_rdata;
  assign chan_data = state.chan;
  assign chan_master_wrote = state.chan_master_wrote;

endmodule // ltc_regs
`default_nettype wire

// ### bench/ltc_monitor.sv
// Checker of the constant bank ports.
// Assumes one clock; bound below into every bank instance, both variants.
`timescale 1ns/1ps
`default_nettype none
module ltc_monitor #(
  parameter bit CONTROLLER = 1'b1
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic req,
  input wire logic req_write,
  input wire logic [15:0] req_addr,
  input wire logic [15:0] req_wdata,
  input wire logic rsp_valid,
  input wire logic rsp_err,
  input wire logic [15:0] rsp_rdata,
  input wire logic prog_write,
  input wire logic [15:0] prog_wdata,
  input wire logic [15:0] chan_data,
  input wire logic chan_master_wrote
);
  localparam logic [15:0] LIM [4] = '{16'h7fff, 16'h8000, 16'h3fff, 16'hc000};
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);
  wire rd = req && !req_write;
  wire chan_wr = req && req_write && req_addr == 16'h1040;
  req_answer_a:
    assert property (req |=> rsp_valid) else $error("no answer");
  idle_quiet_a:
    assert property (!req |=> !rsp_valid && rsp_rdata == 16'h0) else $error("stray");
  clear_read_a:
    assert property (rd && req_addr == 16'h2000 |=> rsp_rdata == 16'h0) else $error("zero");
  all_set_a:
    assert property (rd && req_addr == 16'h2001 |=> rsp_rdata == 16'hffff) else $error("ones");
  order_read_a:
    assert property (rd && req_addr == 16'h2002 |=> rsp_rdata == 16'h1234) else $error("order");
  mask_pair_a:
    assert property (rd && req_addr inside {16'h2003, 16'h2004} |=> rsp_rdata ==
      ($past(req_addr) == 16'h2003 ? 16'haaaa : 16'h5555)) else $error("mask");
  limits_read_a:
    assert property (rd && req_addr inside {[16'h2005:16'h2008]} |=>
      rsp_rdata == LIM[$past(req_addr) - 16'h2005]) else $error("limit");
  chan_write_a:
    assert property (CONTROLLER && chan_wr |=>
      chan_master_wrote && chan_data == $past(req_wdata)) else $error("channel");
  const_write_a:
    assert property (req && req_write && req_addr inside {[16'h2000:16'h2008]} |=>
      !rsp_err && !chan_master_wrote) else $error("const write");
  prog_write_a:
    assert property (CONTROLLER && prog_write && !chan_wr |=>
      chan_data == $past(prog_wdata)) else $error("program write");
  coupler_refuse_a:
    assert property (!CONTROLLER && req && req_addr == 16'h1040 |=>
      rsp_err && !chan_master_wrote) else $error("coupler channel");
  coupler_hold_a:
    assert property (!CONTROLLER && prog_write |=> $stable(chan_data)) else $error("coupler hold");
  cover property (rd ##1 rd);
  cover property (req && req_write && req_addr == 16'h1040);
  cover property (rsp_err);
  cover property (!CONTROLLER && req && req_addr == 16'h1040);
endmodule // ltc_monitor
bind ltc_regs ltc_monitor #(.CONTROLLER(PROGRAMMABLE_CONTROLLER_CORE)) mon (
  .clk(clk), .rstn(rstn), .req(req), .req_write(req_write), .req_addr(req_addr),
  .req_wdata(req_wdata), .rsp_valid(rsp_valid), .rsp_err(rsp_err), .rsp_rdata(rsp_rdata),
  .prog_write(prog_write), .prog_wdata(prog_wdata), .chan_data(chan_data),
  .chan_master_wrote(chan_master_wrote)
);
`default_nettype wire

// ### bench/ltc_master.sv
// Remote master model: takes answers, undoes a byte swap.
// Assumes answers come one cycle after each request.
`timescale 1ns/1ps
`default_nettype none
module ltc_master (
  input wire logic clk,
  input wire logic rstn,
  input wire logic rsp_valid,
  input wire logic [15:0] rsp_rdata,
  output logic [15:0] rx_word
);
  logic swap;
  // Sticky until reset
  always_ff @(posedge clk or negedge rstn)
    if (!rstn) swap <= 1'b0;
    else if (rsp_valid && rsp_rdata == 16'h3412) swap <= 1'b1;
  assign rx_word = swap ? {rsp_rdata[7:0], rsp_rdata[15:8]} : rsp_rdata;
endmodule // ltc_master
`default_nettype wire

// ### bench/tb_top.sv
// Bench: table reads, then writes, channel and reset.
// Assumes the master model on the answer side.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic clk = 0, rstn = 0, req = 0, req_write = 0, prog_write = 0;
  logic [15:0] req_addr = 16'h0, req_wdata = 16'h0, prog_wdata = 16'h0;
  logic rsp_valid, rsp_err, chan_master_wrote;
  logic [15:0] rsp_rdata, chan_data, rx_word;
  logic cp_rsp_err;
  logic [15:0] cp_rsp_rdata, cp_chan_data;
  int fail_count = 0, checked = 0;
  logic [31:0] rows [9] = '{32'h2000_0000, 32'h2001_ffff, 32'h2002_1234, 32'h2003_aaaa,
    32'h2004_5555, 32'h2005_7fff, 32'h2006_8000, 32'h2007_3fff, 32'h2008_c000};
  always #25 clk = ~clk;
  ltc_regs dut (
    .clk(clk), .rstn(rstn), .req(req), .req_write(req_write), .req_addr(req_addr),
    .req_wdata(req_wdata), .rsp_valid(rsp_valid), .rsp_err(rsp_err), .rsp_rdata(rsp_rdata),
    .prog_write(prog_write), .prog_wdata(prog_wdata), .chan_data(chan_data),
    .chan_master_wrote(chan_master_wrote)
  );
  // Coupler variant on the same stimulus
  ltc_regs #(.PROGRAMMABLE_CONTROLLER_CORE(1'b0)) dut_coupler (
    .clk(clk), .rstn(rstn), .req(req), .req_write(req_write), .req_addr(req_addr),
    .req_wdata(req_wdata), .rsp_valid(), .rsp_err(cp_rsp_err), .rsp_rdata(cp_rsp_rdata),
    .prog_write(prog_write), .prog_wdata(prog_wdata), .chan_data(cp_chan_data),
    .chan_master_wrote()
  );
  ltc_master far (
    .clk(clk), .rstn(rstn), .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata), .rx_word(rx_word)
  );
  task automatic check(input logic [16:0] seen, want);
    checked++;
    if (seen !== want) begin
      fail_count++;
      $display("MISMATCH t=%0t seen=%h want=%h", $time, seen, want);
    end
  endtask
  task automatic stop_test;
    $display("checked=%0d fail_count=%0d", checked, fail_count);
    if (checked > 0 && fail_count == 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  // Want holds the error flag above the data
  task automatic access(input logic w, input logic [15:0] a, d, input logic [16:0] want);
    @(posedge clk);
    req <= 1'b1;
    req_write <= w;
    req_addr <= a;
    req_wdata <= d;
    @(posedge clk);
    req <= 1'b0;
    #1 check({rsp_err, rsp_rdata}, want);
  endtask
  initial begin
    repeat (3) @(posedge clk);
    rstn <= 1'b1;
    // Back to back, every row twice
    for (int i = 0; i <= 18; i++) begin
      @(posedge clk);
      req <= i < 18;
      req_addr <= rows[i % 9][31:16];
      #1;
      if (i > 0) begin
        check(rx_word, rows[(i - 1) % 9][15:0]);
        check({cp_rsp_err, cp_rsp_rdata}, {1'b0, rows[(i - 1) % 9][15:0]});
      end
    end
    $display("table reads done");
    for (int i = 0; i < 9; i++) begin
      access(1'b1, rows[i][31:16], ~rows[i][15:0], 17'h0);
      access(1'b0, rows[i][31:16], 16'h0, rows[i][15:0]);
    end
    access(1'b1, 16'h1040, 16'h3c5a, 17'h0);
    check(chan_data, 16'h3c5a);
    check({cp_rsp_err, cp_rsp_rdata}, 17'h10000);
    check(cp_chan_data, 16'h0);
    access(1'b0, 16'h1040, 16'h0, 17'h3c5a);
    check({cp_rsp_err, cp_rsp_rdata}, 17'h10000);
    access(1'b0, 16'h2009, 16'h0, 17'h10000);
    @(posedge clk);
    prog_write <= 1'b1;
    prog_wdata <= 16'h0f0f;
    @(posedge clk);
    prog_write <= 1'b0;
    #1 check(chan_data, 16'h0f0f);
    check(cp_chan_data, 16'h0);
    // Master swaps every word once it has seen the swapped probe value
    access(1'b1, 16'h1040, 16'h3412, 17'h0);
    access(1'b0, 16'h1040, 16'h0, 17'h3412);
    access(1'b0, 16'h2002, 16'h0, 17'h1234);
    check(rx_word, 16'h3412);
    @(posedge clk);
    rstn <= 1'b0;
    @(posedge clk);
    rstn <= 1'b1;
    #1 check(chan_data, 16'h0);
    access(1'b0, 16'h2002, 16'h0, 17'h1234);
    check(rx_word, 16'h1234);
    $display("write and channel tests done");
    stop_test;
  end
  initial begin
    #20000;
    fail_count++;
    stop_test;
  end
endmodule // tb_top
`default_nettype wire
